// [logic/naite_exec.sv]
/*
 * Execution unit for accumulator, port and transfer instructions of a 4-bit core.
 * Assumes the fetch logic presents both words of an instruction with a one-cycle
 * valid strobe, and that program memory answers rom_addr_o combinationally.
 */
`timescale 1ns/1ps
`include "naite_map.svh"
module naite_exec #(
	parameter int GROUPS = 2,
	parameter int PER_GROUP = 4
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic issue_i,
	input wire naite_pkg::naite_instr_s instr_i,
	input wire logic [1:0] rom_page_i,
	output logic [9:0] rom_addr_o,
	input wire logic [9:0] rom_data_i,
	input wire logic [GROUPS*PER_GROUP*4-1:0] port_pins_i,
	output logic [GROUPS*PER_GROUP*4-1:0] port_latch_o,
	output logic [3:0] acc_o,
	output logic carry_flag_o,
	output logic reset_req_o
);
	localparam int NPORT = GROUPS * PER_GROUP;

	// Refused at elaboration: the slot decode below is written for two groups of four
	if (GROUPS != 2 || PER_GROUP != 4)
	begin : g_bad_param
		$error("naite_exec: port decode serves two groups of four ports only");
	end

	// Opcode match under a mask
	function automatic logic op_is(input logic [9:0] w, input logic [9:0] m, input logic [9:0] v);
		return (w & m) == v;
	endfunction

	// Port index 0,1,3,4 to a slot 0..3; other indices are not ports
	function automatic logic [3:0] port_slot(input logic grp, input logic [2:0] n);
		logic [3:0] s;
		s = 4'h8;
		unique case (n)
			`NAITE_PIDX_0: s = {1'b0, grp, 2'h0};
			`NAITE_PIDX_1: s = {1'b0, grp, 2'h1};
			`NAITE_PIDX_3: s = {1'b0, grp, 2'h2};
			`NAITE_PIDX_4: s = {1'b0, grp, 2'h3};
			default: s = 4'h8;
		endcase
		// Bit 3 flags a code that names no port; bits 2:0 are group and slot
		return s;
	endfunction

	// Classify the first word
	function automatic naite_pkg::naite_op_e decode(input logic [9:0] w);
		naite_pkg::naite_op_e o;
		o = naite_pkg::OP_NONE;
		if (op_is(w, `NAITE_M_HL, `NAITE_OP_XOR_ROM)) o = naite_pkg::OP_XOR_ROM;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_XOR_IMM)) o = naite_pkg::OP_XOR_IMM;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_INC)) o = naite_pkg::OP_INC;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_RL)) o = naite_pkg::OP_RL;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_RLZ)) o = naite_pkg::OP_RLZ;
		else if (op_is(w, `NAITE_M_PORT, `NAITE_OP_PIN)) o = naite_pkg::OP_PIN;
		else if (op_is(w, `NAITE_M_PORT, `NAITE_OP_POUT)) o = naite_pkg::OP_POUT;
		else if (op_is(w, `NAITE_M_PORT, `NAITE_OP_PAND)) o = naite_pkg::OP_PAND;
		else if (op_is(w, `NAITE_M_PORT, `NAITE_OP_POR)) o = naite_pkg::OP_POR;
		else if (op_is(w, `NAITE_M_PORT, `NAITE_OP_PXOR)) o = naite_pkg::OP_PXOR;
		else if (op_is(w, `NAITE_M_PAIRP, `NAITE_OP_PIMM8)) o = naite_pkg::OP_PIMM8;
		else if (op_is(w, `NAITE_M_REG, `NAITE_OP_MOVREG)) o = naite_pkg::OP_MOVREG;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_LDH)) o = naite_pkg::OP_LDH;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_LDL)) o = naite_pkg::OP_LDL;
		else if (op_is(w, `NAITE_M_FULL, `NAITE_OP_LDIMM)) o = naite_pkg::OP_LDIMM;
		else if (op_is(w, `NAITE_M_PAIR, `NAITE_OP_PAIRIMM)) o = naite_pkg::OP_PAIRIMM;
		else if (op_is(w, `NAITE_M_PAIR, `NAITE_OP_PAIRROM)) o = naite_pkg::OP_PAIRROM;
		return o;
	endfunction

	logic [3:0] acc;
	logic carry_flag;
	logic reset_req;
	logic [3:0] next_acc;
	logic next_carry;
	logic next_reset_req;
	logic [NPORT*4-1:0] pins_sync;
	logic [7:0] rom_pointer_pair;
	logic [3:0] reg_rd;
	naite_pkg::naite_pairwr_s pair_wr;
	naite_pkg::naite_op_e op;
	logic [3:0] slot;
	logic slot_ok;
	logic [3:0] port_val;
	logic [3:0] rom_nib;
	logic [2:0] hi_slot;

	naite_port_sync #(.WIDTH(NPORT*4)) u_sync (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pins_i(port_pins_i),
		.sync_o(pins_sync)
	);

	naite_regfile #(.DEPTH(16)) u_regs (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.wr_i(pair_wr),
		.rd_bank_i(instr_i.w1[`NAITE_F_GROUP]),
		.rd_idx_i(instr_i.w1[`NAITE_F_RIDX]),
		.rd_data_o(reg_rd),
		.pair0_o(rom_pointer_pair)
	);

	// Pointer address: page bits on top, pair 0 below
	assign rom_addr_o = {rom_page_i, rom_pointer_pair};

	// Decode and operand selection
	assign op = issue_i ? decode(instr_i.w1) : naite_pkg::OP_NONE;
	assign slot = port_slot(instr_i.w1[`NAITE_F_GROUP], instr_i.w1[`NAITE_F_PIDX]);
	assign slot_ok = !slot[3];
	assign hi_slot = slot[2:0] | 3'h4;
	assign port_val = pins_sync[slot[2:0]*4 +: 4];
	assign rom_nib = instr_i.w1[`NAITE_F_LOW] ? rom_data_i[`NAITE_F_ROML] : rom_data_i[`NAITE_F_ROMH];

	// Pair writes to the register file; pair 0 is not a ROM transfer target
	always_comb
	begin
		pair_wr = '0;
		pair_wr.idx = instr_i.w1[`NAITE_F_RIDX];
		if (op == naite_pkg::OP_PAIRIMM)
		begin
			pair_wr.en = 1'b1;
			pair_wr.hi = instr_i.w2[`NAITE_F_DHI];
			pair_wr.lo = instr_i.w2[`NAITE_F_DLO];
		end
		else if (op == naite_pkg::OP_PAIRROM && pair_wr.idx != 4'h0)
		begin
			pair_wr.en = 1'b1;
			pair_wr.hi = rom_data_i[`NAITE_F_ROMH];
			pair_wr.lo = rom_data_i[`NAITE_F_ROML];
		end
	end

	// Accumulator, carry and reset request
	always_comb
	begin
		next_acc = acc;
		next_carry = carry_flag;
		next_reset_req = 1'b0;
		unique case (op)
			naite_pkg::OP_XOR_ROM:
			begin
				next_acc = acc ^ rom_nib;
				next_carry = acc[`NAITE_F_MSB] & rom_nib[`NAITE_F_MSB];
			end
			naite_pkg::OP_XOR_IMM:
			begin
				next_acc = acc ^ instr_i.w2[`NAITE_F_DLO];
				next_carry = acc[`NAITE_F_MSB] & instr_i.w2[`NAITE_F_MSB];
			end
			naite_pkg::OP_INC:
			begin
				next_acc = acc + 4'h1;
				next_carry = (acc == 4'hF);
			end
			naite_pkg::OP_RL:
			begin
				next_acc = {acc[2:0], acc[3]};
				next_carry = acc[3];
			end
			naite_pkg::OP_RLZ:
			begin
				if (acc == `NAITE_RST_NIB)
					next_reset_req = 1'b1;
				else
				begin
					next_acc = {acc[2:0], acc[3]};
					next_carry = acc[3];
				end
			end
			naite_pkg::OP_PIN:
				if (slot_ok)
					next_acc = port_val;
			naite_pkg::OP_PAND:
				if (slot_ok)
				begin
					next_acc = acc & port_val;
					next_carry = acc[3] & port_val[3];
				end
			naite_pkg::OP_POR:
				if (slot_ok)
				begin
					next_acc = acc | port_val;
					next_carry = 1'b0;
				end
			naite_pkg::OP_PXOR:
				if (slot_ok)
				begin
					next_acc = acc ^ port_val;
					next_carry = acc[3] & port_val[3];
				end
			naite_pkg::OP_MOVREG:
			begin
				next_acc = reg_rd;
				next_carry = 1'b0;
			end
			naite_pkg::OP_LDH:
			begin
				next_acc = rom_data_i[`NAITE_F_ROMH];
				next_carry = 1'b0;
			end
			naite_pkg::OP_LDL:
			begin
				next_acc = rom_data_i[`NAITE_F_ROML];
				next_carry = 1'b0;
			end
			naite_pkg::OP_LDIMM:
			begin
				next_acc = instr_i.w2[`NAITE_F_DLO];
				next_carry = 1'b0;
			end
			default:
			begin
				next_acc = acc;
				next_carry = carry_flag;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			acc <= `NAITE_RST_NIB;
			carry_flag <= 1'b0;
			reset_req <= 1'b0;
		end
		else
		begin
			acc <= next_acc;
			carry_flag <= next_carry;
			reset_req <= next_reset_req;
		end
	end

	// Port output latches; an illegal index leaves every latch alone
	for (genvar p = 0; p < NPORT; p++)
	begin : g_port
		logic [3:0] latch;
		logic [3:0] next_latch;
		always_comb
		begin
			next_latch = latch;
			if (op == naite_pkg::OP_POUT && slot_ok && slot[2:0] == 3'(p))
				next_latch = acc;
			else if (op == naite_pkg::OP_PIMM8 && slot_ok && hi_slot == 3'(p))
				next_latch = instr_i.w2[`NAITE_F_DHI];
			else if (op == naite_pkg::OP_PIMM8 && slot_ok && {1'b0, slot[1:0]} == 3'(p))
				next_latch = instr_i.w2[`NAITE_F_DLO];
		end
		always_ff @(posedge clk_i)
		begin
			if (!nrst_i)
				latch <= `NAITE_RST_NIB;
			else
				latch <= next_latch;
		end
		assign port_latch_o[p*4 +: 4] = latch;
	end

	assign acc_o = acc;
	assign carry_flag_o = carry_flag;
	assign reset_req_o = reset_req;

	// Checks on the registered results
	sequence rlz_zero_s;
		op == naite_pkg::OP_RLZ && acc == 4'h0;
	endsequence

	sequence rlz_rot_s;
		op == naite_pkg::OP_RLZ && acc != 4'h0;
	endsequence

	rlz_zero_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rlz_zero_s |=> reset_req && acc == 4'h0 ##1 !reset_req)
		else $error("zero rotate did not raise a one-cycle reset request");

	rlz_rotate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rlz_rot_s |=> !reset_req && acc == {$past(acc[2:0]), $past(acc[3])} && carry_flag == $past(acc[3]))
		else $error("nonzero rotate wrong or reset raised");

	rl_rotate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_RL |=> acc == {$past(acc[2:0]), $past(acc[3])} && carry_flag == $past(acc[3]))
		else $error("rotate left result or carry wrong");

	inc_wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_INC |=> acc == $past(acc) + 4'h1 && carry_flag == (acc == 4'h0))
		else $error("increment result or carry wrong");

	xor_imm_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_XOR_IMM |=> acc == ($past(acc) ^ $past(instr_i.w2[3:0]))
		&& carry_flag == ($past(acc[3]) & $past(instr_i.w2[3])))
		else $error("xor immediate wrong");

	ld_imm_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_LDIMM |=> acc == $past(instr_i.w2[3:0]) && !carry_flag)
		else $error("immediate load wrong");

	ld_romh_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_LDH |=> acc == $past(rom_data_i[7:4]) && !carry_flag)
		else $error("high nibble rom load wrong");

	ld_roml_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_LDL |=> acc == $past(rom_data_i[3:0]) && !carry_flag)
		else $error("low nibble rom load wrong");

	pair_imm_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_PAIRIMM && instr_i.w1[3:0] == 4'h0 ##1 op == naite_pkg::OP_NONE
		|-> rom_pointer_pair == {$past(instr_i.w2[8:5]), $past(instr_i.w2[3:0])})
		else $error("pair 0 immediate load did not reach the pointer");

	rom_addr_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rom_addr_o[9:8] == rom_page_i && rom_addr_o[7:0] == rom_pointer_pair)
		else $error("rom pointer address formed wrongly");

	port_out_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		op == naite_pkg::OP_POUT && slot_ok |=> port_latch_o[$past(slot[2:0])*4 +: 4] == $past(acc))
		else $error("port output latch not loaded");
endmodule

// [logic/naite_map.svh]
/*
 * Opcode patterns, field positions and reset values for the nibble execution unit.
 * Assumes it is included by bare name from the two design modules that use it.
 */
// What this block does
// - XOR accumulator with pointed ROM nibble; carry A3-and
// - XOR immediate nibble; carry A3 and data bit3
// - Increment accumulator; carry set on wrap to zero
// - Rotate left; old bit3 to bit0 and carry
// - Rotate left, but zero accumulator triggers reset
// - Port input loads selected port into accumulator
// - AND port into accumulator; carry A3 and port3
// - OR port into accumulator
// - XOR port into accumulator; carry A3 and port3
// - Immediate byte to port pair, high group upper
// - Register to accumulator move, carry cleared
// - Load ROM bits 7-4, ignore bit9, clear carry
// - Load ROM bits 3-0, ignore bit8, clear carry
// - Load immediate nibble into accumulator, clear carry
// - Immediate byte into register pair, bank1 upper
// - ROM word into pair 1-F, bank1 upper
// - ROM pointer is page bits plus pair 0
`ifndef NAITE_MAP_SVH
`define NAITE_MAP_SVH

// Opcode match values and masks
`define NAITE_M_FULL 10'h3FF
`define NAITE_M_HL 10'h3DF
`define NAITE_M_PORT 10'h3D8
`define NAITE_M_PAIRP 10'h3F8
`define NAITE_M_REG 10'h3D0
`define NAITE_M_PAIR 10'h3F0
`define NAITE_OP_XOR_ROM 10'h290
`define NAITE_OP_XOR_IMM 10'h2B1
`define NAITE_OP_INC 10'h293
`define NAITE_OP_RL 10'h393
`define NAITE_OP_RLZ 10'h3B3
`define NAITE_OP_PIN 10'h018
`define NAITE_OP_POUT 10'h098
`define NAITE_OP_PAND 10'h358
`define NAITE_OP_POR 10'h398
`define NAITE_OP_PXOR 10'h298
`define NAITE_OP_PIMM8 10'h0D8
`define NAITE_OP_MOVREG 10'h3C0
`define NAITE_OP_LDH 10'h3D0
`define NAITE_OP_LDL 10'h3F0
`define NAITE_OP_LDIMM 10'h3F1
`define NAITE_OP_PAIRIMM 10'h0C0
`define NAITE_OP_PAIRROM 10'h0E0

// Field positions inside the first and second words
`define NAITE_F_LOW 5
`define NAITE_F_GROUP 5
`define NAITE_F_PIDX 2:0
`define NAITE_F_RIDX 3:0
`define NAITE_F_DLO 3:0
`define NAITE_F_DHI 8:5
`define NAITE_F_ROMH 7:4
`define NAITE_F_ROML 3:0
`define NAITE_F_MSB 3

// Port numbering: slots per group and the legal indices
`define NAITE_PIDX_0 3'h0
`define NAITE_PIDX_1 3'h1
`define NAITE_PIDX_3 3'h3
`define NAITE_PIDX_4 3'h4

// Reset values
`define NAITE_RST_NIB 4'h0
`define NAITE_RST_PAIR 4'h0
`endif

// [logic/naite_pkg.sv]
/*
 * Types shared by the nibble execution unit and its helpers.
 * Assumes naite_map.svh is on the include path.
 */
package naite_pkg;
	// One-hot operation classes
	typedef enum logic [17:0] {
		OP_NONE = 18'h00001,
		OP_XOR_ROM = 18'h00002,
		OP_XOR_IMM = 18'h00004,
		OP_INC = 18'h00008,
		OP_RL = 18'h00010,
		OP_RLZ = 18'h00020,
		OP_PIN = 18'h00040,
		OP_POUT = 18'h00080,
		OP_PAND = 18'h00100,
		OP_POR = 18'h00200,
		OP_PXOR = 18'h00400,
		OP_PIMM8 = 18'h00800,
		OP_MOVREG = 18'h01000,
		OP_LDH = 18'h02000,
		OP_LDL = 18'h04000,
		OP_LDIMM = 18'h08000,
		OP_PAIRIMM = 18'h10000,
		OP_PAIRROM = 18'h20000
	} naite_op_e;

	// Instruction as issued: first word and second word together
	typedef struct packed {
		logic [9:0] w1;
		logic [9:0] w2;
	} naite_instr_s;

	// Pair write request to the register file
	typedef struct packed {
		logic en;
		logic [3:0] idx;
		logic [3:0] hi;
		logic [3:0] lo;
	} naite_pairwr_s;
endpackage

// [logic/naite_port_sync.sv]
/*
 * Two-stage synchroniser for the port input pins.
 * Assumes pins are asynchronous to clk_i; only the second stage is read.
 */
`timescale 1ns/1ps
module naite_port_sync #(
	parameter int WIDTH = 32
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] pins_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("naite_port_sync: WIDTH must be positive");
	end

	// First stage feeds only the second stage
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			meta <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta <= pins_i;
			sync_o <= meta;
		end
	end
endmodule

// [logic/naite_regfile.sv]
/*
 * General register file: two banks of nibble registers, written as pairs.
 * Assumes one pair write per cycle and same-cycle read of current contents.
 */
`timescale 1ns/1ps
`include "naite_map.svh"
module naite_regfile #(
	parameter int DEPTH = 16
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire naite_pkg::naite_pairwr_s wr_i,
	input wire logic rd_bank_i,
	input wire logic [3:0] rd_idx_i,
	output logic [3:0] rd_data_o,
	output logic [7:0] pair0_o
);
	logic [3:0] bank0 [DEPTH];
	logic [3:0] bank1 [DEPTH];

	if (DEPTH != 16)
	begin : g_bad_depth
		$error("naite_regfile: the 4-bit index needs DEPTH 16");
	end

	// Each entry is its own flop group; a pair write hits both banks at one index
	for (genvar g = 0; g < DEPTH; g++)
	begin : g_ent
		logic [3:0] next_b0;
		logic [3:0] next_b1;
		always_comb
		begin
			next_b0 = bank0[g];
			next_b1 = bank1[g];
			if (wr_i.en && wr_i.idx == 4'(g))
			begin
				next_b0 = wr_i.lo;
				next_b1 = wr_i.hi;
			end
		end
		always_ff @(posedge clk_i)
		begin
			if (!nrst_i)
			begin
				bank0[g] <= `NAITE_RST_PAIR;
				bank1[g] <= `NAITE_RST_PAIR;
			end
			else
			begin
				bank0[g] <= next_b0;
				bank1[g] <= next_b1;
			end
		end
	end

	// Read mux straight from the flops
	assign rd_data_o = rd_bank_i ? bank1[rd_idx_i] : bank0[rd_idx_i];
	assign pair0_o = {bank1[0], bank0[0]};
endmodule

// [testbench/naite_exec_tb_top.sv]
/*
 * Self-checking bench for the nibble execution unit with a reference model.
 * Assumes the far-side model answers memory reads combinationally.
 */
`timescale 1ns/1ps
module naite_exec_tb_top;
	typedef struct packed {
		logic [3:0] acc;
		logic cy;
		logic rq;
		logic [31:0] lat;
	} naite_tb_note_s;

	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic issue_i = 1'b0;
	naite_pkg::naite_instr_s instr_i = '0;
	logic [1:0] rom_page_i = 2'h0;
	logic [9:0] rom_addr_o;
	logic [9:0] rom_data_i;
	logic [31:0] pin_drive = 32'h0;
	logic [31:0] port_pins_i;
	logic [31:0] port_latch_o;
	logic [3:0] acc_o;
	logic carry_flag_o;
	logic reset_req_o;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic taken = 1'b0;
	naite_tb_note_s notes[$];
	naite_tb_note_s seen;
	logic [3:0] m_acc = 4'h0;
	logic m_cy = 1'b0;
	logic [31:0] m_lat = 32'h0;
	logic [3:0] m_b0 [16] = '{default: 4'h0};
	logic [3:0] m_b1 [16] = '{default: 4'h0};

	naite_exec naite_exec_inst (.clk_i(clk_i), .nrst_i(nrst_i), .issue_i(issue_i), .instr_i(instr_i),
		.rom_page_i(rom_page_i), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
		.port_pins_i(port_pins_i), .port_latch_o(port_latch_o), .acc_o(acc_o),
		.carry_flag_o(carry_flag_o), .reset_req_o(reset_req_o));
	naite_far_side naite_far_side_inst (.rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
		.pin_drive_i(pin_drive), .port_pins_o(port_pins_i));

	always #20 clk_i = ~clk_i;

	// Expected memory contents, kept apart from the model's own copy
	function automatic logic [9:0] rom_word(input logic [9:0] a);
		rom_word = {a[4:0], a[9:5]} ^ 10'h15A;
	endfunction

	// Port index to slot within a group; 4 means no such port
	function automatic int slot_of(input logic [2:0] p);
		case (p)
			3'h0: slot_of = 0;
			3'h1: slot_of = 1;
			3'h3: slot_of = 2;
			3'h4: slot_of = 3;
			default: slot_of = 4;
		endcase
	endfunction

	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One thin compare per kind of result, all counted by the same core
	task automatic compare_acc(input logic [3:0] got, input logic [3:0] exp);
		compare({28'h0, got}, {28'h0, exp});
	endtask

	task automatic compare_flags(input logic [1:0] got, input logic [1:0] exp);
		compare({30'h0, got}, {30'h0, exp});
	endtask

	task automatic compare_latch(input logic [31:0] got, input logic [31:0] exp);
		compare(got, exp);
	endtask

	task automatic compare_addr(input logic [9:0] got, input logic [9:0] exp);
		compare({22'h0, got}, {22'h0, exp});
	endtask

	task automatic complete_run();
		$display("compares=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Issue one instruction back to back and note what the outputs must become
	task automatic run_op(input logic [9:0] w1, input logic [9:0] w2);
		naite_tb_note_s n;
		logic [3:0] a;
		logic [3:0] pv;
		logic [3:0] rn;
		logic [9:0] rw;
		int k;
		int s;
		@(negedge clk_i);
		issue_i = 1'b1;
		instr_i = {w1, w2};
		a = m_acc;
		rw = rom_word({rom_page_i, m_b1[0], m_b0[0]});
		rn = w1[5] ? rw[3:0] : rw[7:4];
		k = slot_of(w1[2:0]);
		s = (k < 4) ? ((w1[5] ? 4 : 0) + k) : 0;
		pv = pin_drive[s*4 +: 4];
		n.rq = 1'b0;
		if ((w1 & 10'h3DF) == 10'h290)
			{m_acc, m_cy} = {a ^ rn, a[3] & rn[3]};
		else if (w1 == 10'h2B1)
			{m_acc, m_cy} = {a ^ w2[3:0], a[3] & w2[3]};
		else if (w1 == 10'h293)
			{m_acc, m_cy} = {a + 4'h1, a == 4'hF};
		else if (w1 == 10'h393 || (w1 == 10'h3B3 && a != 4'h0))
			{m_acc, m_cy} = {a[2:0], a[3], a[3]};
		else if (w1 == 10'h3B3)
			n.rq = 1'b1;
		else if ((w1 & 10'h3D8) == 10'h018 && k < 4)
			m_acc = pv;
		else if ((w1 & 10'h3D8) == 10'h098 && k < 4)
			m_lat[s*4 +: 4] = a;
		else if ((w1 & 10'h3D8) == 10'h358 && k < 4)
			{m_acc, m_cy} = {a & pv, a[3] & pv[3]};
		else if ((w1 & 10'h3D8) == 10'h398 && k < 4)
			{m_acc, m_cy} = {a | pv, 1'b0};
		else if ((w1 & 10'h3D8) == 10'h298 && k < 4)
			{m_acc, m_cy} = {a ^ pv, a[3] & pv[3]};
		else if ((w1 & 10'h3F8) == 10'h0D8 && k < 4)
			{m_lat[(4 + k)*4 +: 4], m_lat[k*4 +: 4]} = {w2[8:5], w2[3:0]};
		else if ((w1 & 10'h3D0) == 10'h3C0)
			{m_acc, m_cy} = {w1[5] ? m_b1[w1[3:0]] : m_b0[w1[3:0]], 1'b0};
		else if (w1 == 10'h3D0 || w1 == 10'h3F0)
			{m_acc, m_cy} = {rn, 1'b0};
		else if (w1 == 10'h3F1)
			{m_acc, m_cy} = {w2[3:0], 1'b0};
		else if ((w1 & 10'h3F0) == 10'h0C0)
			{m_b1[w1[3:0]], m_b0[w1[3:0]]} = {w2[8:5], w2[3:0]};
		else if ((w1 & 10'h3F0) == 10'h0E0 && w1[3:0] != 4'h0)
			{m_b1[w1[3:0]], m_b0[w1[3:0]]} = rw[7:0];
		n.acc = m_acc;
		n.cy = m_cy;
		n.lat = m_lat;
		notes.push_back(n);
	endtask

	// Results land at the taking edge; read them half a cycle later
	always @(posedge clk_i)
		taken <= issue_i;

	always @(negedge clk_i)
	begin
		if (taken && notes.size() > 0)
		begin
			seen = notes.pop_front();
			compare_acc(acc_o, seen.acc);
			compare_flags({carry_flag_o, reset_req_o}, {seen.cy, seen.rq});
			compare_latch(port_latch_o, seen.lat);
		end
	end

	// A hang is cut off well past the expected run length
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			complete_run();
		end
	end

	initial
	begin
		void'($urandom(12));
		repeat (5) @(negedge clk_i);
		nrst_i = 1'b1;
		run_op(10'h000, 10'h000);
		// Accumulator arithmetic, including the wrap and the zero rotate
		for (int i = 0; i < 16; i++)
		begin
			run_op(10'h3F1, 10'(i));
			run_op(10'h293, 10'h000);
			run_op(10'h393, 10'h000);
			run_op(10'h3B3, 10'h000);
			run_op(10'h2B1, 10'($urandom) & 10'h00F);
		end
		// Fill every pair, then read both banks back
		for (int i = 0; i < 16; i++)
			run_op(10'h0C0 | 10'(i), 10'($urandom) & 10'h1EF);
		for (int i = 0; i < 32; i++)
			run_op({4'hF, i[4], 1'b0, i[3:0]}, 10'h000);
		// Pointer reads over random pages and pointers; pair 0 target is ignored
		for (int i = 0; i < 16; i++)
		begin
			run_op(10'h0C0, 10'($urandom) & 10'h1EF);
			@(negedge clk_i);
			issue_i = 1'b0;
			compare_addr(rom_addr_o, {rom_page_i, m_b1[0], m_b0[0]});
			run_op(10'h3D0, 10'h000);
			run_op(10'h3F0, 10'h000);
			run_op(10'h290, 10'h000);
			run_op(10'h2B0, 10'h000);
			run_op(10'h0E0 | 10'(i), 10'h000);
			run_op({4'hF, 1'b1, 1'b0, 4'(i)}, 10'h000);
			run_op({4'hF, 1'b0, 1'b0, 4'(i)}, 10'h000);
			@(negedge clk_i);
			issue_i = 1'b0;
			rom_page_i = 2'($urandom);
		end
		// Port traffic over both groups and all eight index codes
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk_i);
			issue_i = 1'b0;
			pin_drive = $urandom;
			repeat (3) @(negedge clk_i);
			for (int j = 0; j < 16; j++)
			begin
				logic [9:0] pf;
				pf = {4'h0, j[3], 2'h0, j[2:0]};
				run_op(10'h3F1, 10'($urandom) & 10'h00F);
				run_op(10'h358 | pf, 10'h000);
				run_op(10'h3F1, 10'($urandom) & 10'h00F);
				run_op(10'h298 | pf, 10'h000);
				run_op(10'h398 | pf, 10'h000);
				run_op(10'h018 | pf, 10'h000);
				run_op(10'h3F1, 10'($urandom) & 10'h00F);
				run_op(10'h098 | pf, 10'h000);
				run_op(10'h0D8 | {7'h0, j[2:0]}, 10'($urandom) & 10'h1EF);
			end
		end
		@(negedge clk_i);
		issue_i = 1'b0;
		repeat (3) @(negedge clk_i);
		complete_run();
	end
endmodule

// [testbench/naite_far_side.sv]
/*
 * Far-side model for the nibble execution unit: program memory and port pins.
 * Assumes the bench chooses pin levels and that the memory answers at once.
 */
`timescale 1ns/1ps
module naite_far_side
(
	input wire logic [9:0] rom_addr_i,
	output logic [9:0] rom_data_o,
	input wire logic [31:0] pin_drive_i,
	output logic [31:0] port_pins_o
);
	// Scrambled contents so each word differs; answered in the same cycle
	always_comb
		rom_data_o = {rom_addr_i[4:0], rom_addr_i[9:5]} ^ 10'h15A;
	// Pins are driven hard by the bench, so no pull level is modelled
	assign port_pins_o = pin_drive_i;
endmodule
